// file: src/serial_port_pkg.sv
// package: register map, encodings and timing constants of the serial port
// What this block does
// - no parity: eight data bits; else seven
// - six baud rates; far end matches the rate
// - five flow control modes selectable by software
// - xoff character 13h halts the transmitter
// - xon character 11h resumes the transmitter
// - dtr/dsr mode: send only while dsr
// - dtr/dsr mode: drop dtr when nearly full
// - rts/cts mode: send only while cts
// - rts/cts mode: drop rts when nearly full
// - modem mode: dtr high while port selected
// - modem mode: rts drops when nearly full
// - print option streams readings without request
package serial_port_pkg;
  // ----------------------------------------
  // clock and bit timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20000000; // mclk rate
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_57600 = 57600;
  localparam int unsigned BAUD_115200 = 115200;
  localparam int unsigned DIV_W = 13; // wide enough for the slowest rate
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [3:0] OFF_CTRL = 4'h0; // mode, parity, baud, enables
  localparam logic [3:0] OFF_STAT = 4'h4; // live flow and buffer state
  localparam logic [3:0] OFF_TXD = 4'h8; // write: queue a byte
  localparam logic [3:0] OFF_RXD = 4'hc; // read: pop a byte
  // ctrl field positions
  localparam int unsigned CTRL_FLOW_LSB = 0; // 3 bits
  localparam int unsigned CTRL_PAR_LSB = 3; // 2 bits
  localparam int unsigned CTRL_BAUD_LSB = 5; // 3 bits
  localparam int unsigned CTRL_SEL_BIT = 8; // serial interface selected
  localparam int unsigned CTRL_PRINT_BIT = 9; // reading output enable
  localparam logic [9:0] CTRL_RESET = 10'h020; // 9600, no parity, no flow
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [2:0] FLOW_NONE = 3'h0;
  localparam logic [2:0] FLOW_SOFT = 3'h1;
  localparam logic [2:0] FLOW_DTR = 3'h2;
  localparam logic [2:0] FLOW_RTS = 3'h3;
  localparam logic [2:0] FLOW_MODEM = 3'h4;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam int unsigned ALMOST_FULL = 100; // input buffer threshold
  localparam int unsigned RX_DEPTH = 128;
  localparam int unsigned FRAME_BITS_W = 4;
  localparam logic [3:0] FRAME_BITS = 4'ha; // start, 8 payload, stop

  // cycles per bit for a baud select code
  function automatic logic [DIV_W-1:0] bit_cycles(input logic [2:0] sel);
    int unsigned b;
    case (sel)
      3'h0: b = BAUD_4800;
      3'h1: b = BAUD_9600;
      3'h2: b = BAUD_19200;
      3'h3: b = BAUD_38400;
      3'h4: b = BAUD_57600;
      default: b = BAUD_115200;
    endcase
    bit_cycles = DIV_W'(CLK_HZ / b);
  endfunction : bit_cycles
endpackage : serial_port_pkg

// file: src/serial_port.sv
// serial port with selectable parity, baud rate and flow control
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module serial_port #(
  parameter int unsigned RX_DEPTH = serial_port_pkg::RX_DEPTH,
  parameter int unsigned ALMOST_FULL = serial_port_pkg::ALMOST_FULL
) (
  input wire logic mclk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // measurement readings to stream out
  input wire logic [7:0] rdg_data,
  input wire logic rdg_valid,
  output logic rdg_ready,
  // line pins
  input wire logic rxd,
  output logic txd,
  input wire logic dsr,
  input wire logic cts,
  output logic dtr,
  output logic rts
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  localparam int unsigned AW = $clog2(RX_DEPTH);
  // pointers wrap at a power of two; the status count field fits depths up to the default only
  if (ALMOST_FULL >= RX_DEPTH || ALMOST_FULL == 0 || RX_DEPTH > serial_port_pkg::RX_DEPTH
    || RX_DEPTH != (32'h1 << AW))
  begin : g_bad_cfg
    $error("buffer depth or almost full threshold not supported");
  end

  // ----------------------------------------
  // control register and its fields
  // ----------------------------------------
  logic [9:0] ctrl_r; // held settings, keep across cycles of use
  logic [2:0] flow; // active flow mode
  logic [1:0] par; // parity selection
  logic sel; // serial interface selected
  logic print_en; // stream readings
  logic [serial_port_pkg::DIV_W-1:0] bit_len; // cycles per bit
  assign flow = ctrl_r[serial_port_pkg::CTRL_FLOW_LSB +: 3];
  assign par = ctrl_r[serial_port_pkg::CTRL_PAR_LSB +: 2];
  assign sel = ctrl_r[serial_port_pkg::CTRL_SEL_BIT];
  assign print_en = ctrl_r[serial_port_pkg::CTRL_PRINT_BIT];
  assign bit_len = serial_port_pkg::bit_cycles(ctrl_r[serial_port_pkg::CTRL_BAUD_LSB +: 3]);

  // bus decode; every access answers on the cycle after it is seen
  logic ack_r; // one-cycle answer pulse
  logic acc; // a request awaiting its answer
  logic wr_ctrl, wr_txd, rd_rxd;
  assign acc = (avs_read | avs_write) & ~ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_ctrl = avs_write & ack_r & (avs_address == serial_port_pkg::OFF_CTRL);
  assign wr_txd = avs_write & ack_r & (avs_address == serial_port_pkg::OFF_TXD);
  assign rd_rxd = avs_read & ack_r & (avs_address == serial_port_pkg::OFF_RXD);

  // answer one cycle after the request rises
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      ack_r <= 1'b0;
    else
      ack_r <= acc;
  end

  // settings register
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      ctrl_r <= serial_port_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_r <= avs_writedata[9:0];
  end

  // ----------------------------------------
  // two-entry transmit buffer
  // ----------------------------------------
  logic [7:0] tq_mem_r [2]; // entries
  logic [1:0] tq_cnt_r; // fill level
  logic tq_wp_r, tq_rp_r; // pointers
  logic tq_in_valid, tq_in_ready, tq_out_valid, tq_out_ready;
  logic [7:0] tq_in_data;
  // software bytes win over readings; readings only stream when printing
  assign tq_in_valid = wr_txd | (print_en & rdg_valid);
  assign tq_in_data = wr_txd ? avs_writedata[7:0] : rdg_data;
  assign tq_in_ready = (tq_cnt_r != 2'h2);
  assign rdg_ready = print_en & tq_in_ready & ~wr_txd;
  assign tq_out_valid = (tq_cnt_r != 2'h0);
  logic tq_push, tq_pop;
  assign tq_push = tq_in_valid & tq_in_ready;
  assign tq_pop = tq_out_valid & tq_out_ready;

  // buffer storage and pointers; a full buffer drops a bus write
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      tq_cnt_r <= 2'h0;
      tq_wp_r <= 1'b0;
      tq_rp_r <= 1'b0;
    end
    else
    begin
      if (tq_push)
      begin
        tq_mem_r[tq_wp_r] <= tq_in_data;
        tq_wp_r <= ~tq_wp_r;
      end
      if (tq_pop)
        tq_rp_r <= ~tq_rp_r;
      tq_cnt_r <= tq_cnt_r + {1'b0, tq_push} - {1'b0, tq_pop};
    end
  end

  // ----------------------------------------
  // transmit pacing
  // ----------------------------------------
  logic xoff_r; // halted by the far end
  logic rx_ctl_xoff, rx_ctl_xon; // control codes seen by the receiver
  logic tx_allow;

  // xoff halts, xon resumes; leaving soft mode clears the halt
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      xoff_r <= 1'b0;
    else if (flow != serial_port_pkg::FLOW_SOFT)
      xoff_r <= 1'b0;
    else if (rx_ctl_xoff)
      xoff_r <= 1'b1;
    else if (rx_ctl_xon)
      xoff_r <= 1'b0;
  end

  // gate the start of each character on the mode's permission
  always_comb
  begin
    case (flow)
      serial_port_pkg::FLOW_SOFT: tx_allow = ~xoff_r;
      serial_port_pkg::FLOW_DTR: tx_allow = dsr;
      serial_port_pkg::FLOW_RTS: tx_allow = cts;
      serial_port_pkg::FLOW_MODEM: tx_allow = dsr & cts;
      default: tx_allow = 1'b1;
    endcase
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
  tx_state_t tx_st_r;
  logic [9:0] tx_sh_r; // frame shift, lsb out first
  logic [3:0] tx_bits_r; // bits left
  logic [serial_port_pkg::DIV_W-1:0] tx_div_r;
  logic [7:0] tx_byte;
  logic tx_parbit;
  assign tx_byte = tq_mem_r[tq_rp_r];
  // odd parity makes the ones count odd across seven bits plus parity
  assign tx_parbit = (^tx_byte[6:0]) ^ (par == serial_port_pkg::PAR_ODD);
  assign tq_out_ready = (tx_st_r == TX_IDLE) & tx_allow;

  // shift one frame out; a character in flight always completes
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 10'h3ff;
      tx_bits_r <= 4'h0;
      tx_div_r <= '0;
    end
    else
    begin
      case (tx_st_r)
        TX_IDLE:
        begin
          if (tq_pop)
          begin
            // stop, payload, start; parity replaces bit 7
            tx_sh_r <= {1'b1, (par == serial_port_pkg::PAR_NONE) ? tx_byte[7] : tx_parbit,
              tx_byte[6:0], 1'b0};
            tx_bits_r <= serial_port_pkg::FRAME_BITS;
            tx_div_r <= bit_len - 1'b1;
            tx_st_r <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (tx_div_r != '0)
            tx_div_r <= tx_div_r - 1'b1;
          else
          begin
            tx_div_r <= bit_len - 1'b1;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bits_r <= tx_bits_r - 1'b1;
            if (tx_bits_r == 4'h1)
              tx_st_r <= TX_IDLE;
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end
  assign txd = tx_sh_r[0]; // idle high

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_BITS = 3'b010, RX_DONE = 3'b100} rx_state_t;
  rx_state_t rx_st_r;
  logic rx_s1_r, rx_s2_r; // pin synchroniser
  logic [8:0] rx_sh_r; // payload and stop
  logic [3:0] rx_bits_r;
  logic [serial_port_pkg::DIV_W-1:0] rx_div_r;
  logic [7:0] rx_char;
  logic rx_store;

  // two-flop synchroniser on the data pin
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
    end
  end

  // sample each bit at its middle; a false start returns to idle
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rx_st_r <= RX_IDLE;
      rx_sh_r <= '0;
      rx_bits_r <= 4'h0;
      rx_div_r <= '0;
    end
    else
    begin
      case (rx_st_r)
        RX_IDLE:
        begin
          if (!rx_s2_r)
          begin
            rx_div_r <= bit_len >> 1;
            rx_bits_r <= serial_port_pkg::FRAME_BITS;
            rx_st_r <= RX_BITS;
          end
        end
        RX_BITS:
        begin
          if (rx_div_r != '0)
            rx_div_r <= rx_div_r - 1'b1;
          else
          begin
            rx_div_r <= bit_len - 1'b1;
            rx_bits_r <= rx_bits_r - 1'b1;
            if (rx_bits_r == serial_port_pkg::FRAME_BITS && rx_s2_r)
              rx_st_r <= RX_IDLE; // start bit did not hold
            else if (rx_bits_r != serial_port_pkg::FRAME_BITS)
              rx_sh_r <= {rx_s2_r, rx_sh_r[8:1]};
            if (rx_bits_r == 4'h1)
              rx_st_r <= RX_DONE;
          end
        end
        RX_DONE: rx_st_r <= RX_IDLE;
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // seven data bits when parity is on; the parity bit is dropped
  assign rx_char = (par == serial_port_pkg::PAR_NONE) ? rx_sh_r[7:0] : {1'b0, rx_sh_r[6:0]};
  // a frame with a low stop bit is discarded
  assign rx_ctl_xoff = (rx_st_r == RX_DONE) & rx_sh_r[8] & (flow == serial_port_pkg::FLOW_SOFT)
    & (rx_char == serial_port_pkg::CHAR_XOFF);
  assign rx_ctl_xon = (rx_st_r == RX_DONE) & rx_sh_r[8] & (flow == serial_port_pkg::FLOW_SOFT)
    & (rx_char == serial_port_pkg::CHAR_XON);
  assign rx_store = (rx_st_r == RX_DONE) & rx_sh_r[8] & ~rx_ctl_xoff & ~rx_ctl_xon;

  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  logic [7:0] rb_mem_r [RX_DEPTH];
  logic [AW-1:0] rb_wp_r, rb_rp_r;
  logic [AW:0] rb_cnt_r; // fill level
  logic rb_push, rb_pop;
  assign rb_push = rx_store & (rb_cnt_r != (AW+1)'(RX_DEPTH)); // overflow drops
  assign rb_pop = rd_rxd & (rb_cnt_r != '0);

  // circular buffer of received characters
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rb_wp_r <= '0;
      rb_rp_r <= '0;
      rb_cnt_r <= '0;
    end
    else
    begin
      if (rb_push)
      begin
        rb_mem_r[rb_wp_r] <= rx_char;
        rb_wp_r <= rb_wp_r + 1'b1;
      end
      if (rb_pop)
        rb_rp_r <= rb_rp_r + 1'b1;
      rb_cnt_r <= rb_cnt_r + {{AW{1'b0}}, rb_push} - {{AW{1'b0}}, rb_pop};
    end
  end

  // ----------------------------------------
  // receive-side handshake lines
  // ----------------------------------------
  logic nearly_full;
  assign nearly_full = (rb_cnt_r >= (AW+1)'(ALMOST_FULL));

  // ready lines follow mode and buffer level, registered
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dtr <= 1'b0;
      rts <= 1'b0;
    end
    else
    begin
      case (flow)
        serial_port_pkg::FLOW_DTR:
        begin
          dtr <= ~nearly_full;
          rts <= 1'b1;
        end
        serial_port_pkg::FLOW_RTS:
        begin
          dtr <= 1'b1;
          rts <= ~nearly_full;
        end
        serial_port_pkg::FLOW_MODEM:
        begin
          dtr <= sel;
          rts <= sel & ~nearly_full;
        end
        default:
        begin
          dtr <= 1'b1;
          rts <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      avs_readdata <= '0;
    else if (acc)
    begin
      case (avs_address)
        serial_port_pkg::OFF_CTRL: avs_readdata <= {22'h0, ctrl_r};
        // count zero-extended into its eight-bit field
        serial_port_pkg::OFF_STAT: avs_readdata <= {19'h0, 8'(rb_cnt_r), xoff_r, tq_cnt_r,
          2'h0};
        serial_port_pkg::OFF_RXD: avs_readdata <= {24'h0, rb_mem_r[rb_rp_r]};
        default: avs_readdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_xoff_halts: assert property (@(posedge mclk) disable iff (!nrst)
    rx_ctl_xoff |=> xoff_r) else $error("xoff did not halt");
  chk_xon_resumes: assert property (@(posedge mclk) disable iff (!nrst)
    rx_ctl_xon & ~rx_ctl_xoff |=> ~xoff_r) else $error("xon did not resume");
  chk_dsr_gate: assert property (@(posedge mclk) disable iff (!nrst)
    (flow == serial_port_pkg::FLOW_DTR) & ~dsr |-> ~tq_pop) else $error("sent without dsr");
  chk_cts_gate: assert property (@(posedge mclk) disable iff (!nrst)
    (flow == serial_port_pkg::FLOW_RTS) & ~cts |-> ~tq_pop) else $error("sent without cts");
  chk_dtr_full: assert property (@(posedge mclk) disable iff (!nrst)
    (flow == serial_port_pkg::FLOW_DTR) & nearly_full |=> ~dtr) else $error("dtr held");
  chk_rts_full: assert property (@(posedge mclk) disable iff (!nrst)
    (flow == serial_port_pkg::FLOW_RTS) & nearly_full |=> ~rts) else $error("rts held");
  chk_modem_dtr: assert property (@(posedge mclk) disable iff (!nrst)
    (flow == serial_port_pkg::FLOW_MODEM) & sel |=> dtr) else $error("dtr low in modem");
  chk_modem_rts: assert property (@(posedge mclk) disable iff (!nrst)
    (flow == serial_port_pkg::FLOW_MODEM) & nearly_full |=> ~rts) else $error("rts held");
  chk_ctl_unbuffered: assert property (@(posedge mclk) disable iff (!nrst)
    rx_ctl_xoff | rx_ctl_xon |-> ~rb_push) else $error("control code buffered");
  chk_start_bit: assert property (@(posedge mclk) disable iff (!nrst)
    tq_pop |=> ~txd [*2]) else $error("no start bit");
  chk_print_gate: assert property (@(posedge mclk) disable iff (!nrst)
    ~print_en |-> ~rdg_ready) else $error("reading taken while print off");
  cov_tx_frame: cover property (@(posedge mclk) disable iff (!nrst) tq_pop);
  cov_rx_store: cover property (@(posedge mclk) disable iff (!nrst) rb_push);
  cov_xoff: cover property (@(posedge mclk) disable iff (!nrst) rx_ctl_xoff);
  cov_nearly_full: cover property (@(posedge mclk) disable iff (!nrst) nearly_full);
endmodule : serial_port

// file: tb/host_model.sv
// far-end model: serial terminal with flow lines, 115200 baud
`timescale 1ns/100ps
module host_model #(
  parameter int BIT = 173
) (
  input wire logic mclk,
  input wire logic txd,
  input wire logic dtr,
  input wire logic rts,
  output logic rxd,
  output logic dsr,
  output logic cts
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [8:0] got_q[$]; // stop bit and payload of each char heard
  logic listen = 1'b1; // off while the bench cuts frames short
  logic [8:0] sh; // bits of the char being heard
  // rs232 idles at mark, so the released line is high
  initial
  begin
    rxd = 1'b1;
    dsr = 1'b1; // on-line
    cts = 1'b1; // ready for data
  end
  // receiver: mid-bit sampling, lsb first, stop bit kept for judging
  always
  begin
    @(negedge txd);
    if (listen)
    begin
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT) @(posedge mclk);
        sh[i] = txd;
      end
      got_q.push_back(sh);
    end
  end
  // sender: same rate as the device, one char at a time
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0}; // start low, lsb first, stop high
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge mclk);
    end
  endtask : send_char
endmodule : host_model

// file: tb/tb_serial_port.sv
// self-checking bench for the serial port
`timescale 1ns/100ps
module tb_serial_port;
  localparam int AF = 4; // shortened nearly-full threshold
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] rdg_data = 8'h00;
  logic rdg_valid = 1'b0;
  logic rdg_ready, rxd, txd, dsr, cts, dtr, rts;
  int failures = 0;
  int cmp_count = 0;
  logic [31:0] rd; // last read data
  always #25 mclk = ~mclk;
  serial_port #(.RX_DEPTH(8), .ALMOST_FULL(AF)) serial_port_inst (.mclk(mclk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rdg_data(rdg_data), .rdg_valid(rdg_valid),
    .rdg_ready(rdg_ready), .rxd(rxd), .txd(txd), .dsr(dsr), .cts(cts), .dtr(dtr), .rts(rts));
  host_model #(.BIT(173)) host_model_inst (.mclk(mclk), .txd(txd), .dtr(dtr), .rts(rts),
    .rxd(rxd), .dsr(dsr), .cts(cts));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic hang;
    failures++;
    test_done();
  endtask : hang
  task automatic do_reset;
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
  endtask : do_reset
  // avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do
    begin
      @(posedge mclk);
      n++;
      if (n > 20) hang();
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // ctrl word at the fastest rate
  function automatic logic [31:0] ctl(input logic [2:0] fl, input logic [1:0] par,
    input logic sel, input logic pr);
    return {22'h0, pr, sel, 3'h5, par, fl};
  endfunction : ctl
  task automatic expect_tx(input logic [7:0] b);
    int n = 0;
    while (host_model_inst.got_q.size() == 0)
    begin
      @(posedge mclk);
      n++;
      if (n > 4000) hang();
    end
    check(32'(host_model_inst.got_q.pop_front()), {23'h0, 1'b1, b});
  endtask : expect_tx
  // more than a whole frame with nothing heard
  task automatic quiet;
    repeat (2000) @(posedge mclk);
    check(32'(host_model_inst.got_q.size()), 32'h0);
  endtask : quiet
  // fill the input buffer to the threshold, then drain it
  task automatic fill(input logic use_rts);
    for (int i = 0; i < AF; i++) host_model_inst.send_char(8'h80 + 8'(i));
    repeat (4) @(posedge mclk);
    check(32'(use_rts ? rts : dtr), 32'h0);
    for (int i = 0; i < AF; i++)
    begin
      bus(1'b0, serial_port_pkg::OFF_RXD, 32'h0);
      check(rd & 32'hff, 32'h80 + 32'(i));
      repeat (3) @(posedge mclk);
      check(32'(use_rts ? rts : dtr), 32'h1);
    end
  endtask : fill
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    bus(1'b0, serial_port_pkg::OFF_CTRL, 32'h0);
    check(rd, 32'h020);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    check({29'h0, txd, dtr, rts}, 32'h7);
  endtask : t_reset
  // parity sets width: seven data bits plus parity, else eight
  task automatic t_frame;
    logic [1:0] pars[3] = '{serial_port_pkg::PAR_NONE, serial_port_pkg::PAR_ODD,
      serial_port_pkg::PAR_EVEN};
    logic [7:0] outs[3] = '{8'hc3, 8'h43, 8'hc3};
    for (int i = 0; i < 3; i++)
    begin
      // paced mode: the host sends at full rate, which an unpaced link forbids
      bus(1'b1, serial_port_pkg::OFF_CTRL, ctl(serial_port_pkg::FLOW_RTS, pars[i], 1'b1, 1'b0));
      bus(1'b1, serial_port_pkg::OFF_TXD, 32'hc3);
      expect_tx(outs[i]);
    end
    host_model_inst.send_char(8'hc3);
    bus(1'b0, serial_port_pkg::OFF_RXD, 32'h0);
    check(rd & 32'hff, 32'h43);
  endtask : t_frame
  task automatic t_soft;
    bus(1'b1, serial_port_pkg::OFF_CTRL,
      ctl(serial_port_pkg::FLOW_SOFT, serial_port_pkg::PAR_NONE, 1'b1, 1'b0));
    host_model_inst.send_char(serial_port_pkg::CHAR_XOFF);
    repeat (4) @(posedge mclk);
    bus(1'b0, serial_port_pkg::OFF_STAT, 32'h0);
    check(rd & 32'h1ff0, 32'h10);
    bus(1'b1, serial_port_pkg::OFF_TXD, 32'h5a);
    quiet();
    host_model_inst.send_char(serial_port_pkg::CHAR_XON);
    expect_tx(8'h5a);
    bus(1'b0, serial_port_pkg::OFF_STAT, 32'h0);
    check(rd & 32'h1fff, 32'h0);
  endtask : t_soft
  // hardware pacing: the gate input holds the start of a char
  task automatic t_hw(input logic [2:0] fl, input logic use_rts);
    bus(1'b1, serial_port_pkg::OFF_CTRL, ctl(fl, serial_port_pkg::PAR_NONE, 1'b1, 1'b0));
    @(posedge mclk);
    host_model_inst.dsr <= use_rts;
    host_model_inst.cts <= ~use_rts;
    bus(1'b1, serial_port_pkg::OFF_TXD, 32'h66);
    quiet();
    host_model_inst.dsr <= 1'b1;
    host_model_inst.cts <= 1'b1;
    expect_tx(8'h66);
    fill(use_rts);
  endtask : t_hw
  task automatic t_modem;
    bus(1'b1, serial_port_pkg::OFF_CTRL,
      ctl(serial_port_pkg::FLOW_MODEM, serial_port_pkg::PAR_NONE, 1'b0, 1'b0));
    repeat (3) @(posedge mclk);
    check(32'(dtr), 32'h0);
    bus(1'b1, serial_port_pkg::OFF_CTRL,
      ctl(serial_port_pkg::FLOW_MODEM, serial_port_pkg::PAR_NONE, 1'b1, 1'b0));
    repeat (3) @(posedge mclk);
    check({30'h0, dtr, rts}, 32'h3);
    host_model_inst.cts <= 1'b0;
    bus(1'b1, serial_port_pkg::OFF_TXD, 32'h3c);
    quiet();
    host_model_inst.cts <= 1'b1;
    expect_tx(8'h3c);
    fill(1'b1);
    check(32'(dtr), 32'h1);
  endtask : t_modem
  // readings go out unasked; a stalled link fills the two-entry buffer
  task automatic t_print;
    int n = 0;
    bus(1'b1, serial_port_pkg::OFF_CTRL,
      ctl(serial_port_pkg::FLOW_RTS, serial_port_pkg::PAR_NONE, 1'b1, 1'b0));
    check(32'(rdg_ready), 32'h0);
    host_model_inst.cts <= 1'b0;
    bus(1'b1, serial_port_pkg::OFF_CTRL,
      ctl(serial_port_pkg::FLOW_RTS, serial_port_pkg::PAR_NONE, 1'b1, 1'b1));
    rdg_valid <= 1'b1;
    rdg_data <= 8'h70;
    repeat (6)
    begin
      @(posedge mclk);
      if (rdg_ready === 1'b1)
      begin
        n++;
        rdg_data <= 8'h70 + 8'(n);
      end
    end
    rdg_valid <= 1'b0;
    check(32'(n), 32'h2);
    bus(1'b0, serial_port_pkg::OFF_STAT, 32'h0);
    check(rd & 32'hc, 32'h8);
    host_model_inst.cts <= 1'b1;
    expect_tx(8'h70);
    expect_tx(8'h71);
  endtask : t_print
  // start bit length at each rate; reset cuts the frame short
  task automatic t_baud;
    int rates[6] = '{4800, 9600, 19200, 38400, 57600, 115200};
    int n, e;
    host_model_inst.listen = 1'b0;
    for (int s = 0; s < 6; s++)
    begin
      do_reset();
      e = 20000000 / rates[s];
      bus(1'b1, serial_port_pkg::OFF_CTRL, {23'h0, 1'b1, 3'(s), 5'h0});
      bus(1'b1, serial_port_pkg::OFF_TXD, 32'h01);
      n = 0;
      while (txd !== 1'b0)
      begin
        @(posedge mclk);
        n++;
        if (n > 100) hang();
      end
      n = 0;
      while (txd === 1'b0)
      begin
        @(posedge mclk);
        n++;
        if (n > 5000) hang();
      end
      check(32'((n > e ? n - e : e - n) <= 1), 32'h1);
    end
  endtask : t_baud
  initial
  begin
    do_reset();
    t_reset();
    t_frame();
    t_soft();
    t_hw(serial_port_pkg::FLOW_DTR, 1'b0);
    t_hw(serial_port_pkg::FLOW_RTS, 1'b1);
    t_modem();
    t_print();
    t_baud();
    test_done();
  end
endmodule : tb_serial_port
